// ---- verilog/asr_defs.vh ----
`ifndef ASR_DEFS_VH
`define ASR_DEFS_VH

// ****************************************************************
// register word offsets (byte addresses)
// ****************************************************************
`define ASR_OFF_ORD_SEQ3     8'h00
`define ASR_OFF_PRE_SEQ      8'h04
`define ASR_OFF_PRE_RES1     8'h08
`define ASR_OFF_PRE_RES2     8'h0C
`define ASR_OFF_PRE_RES3     8'h10
`define ASR_OFF_PRE_RES4     8'h14
`define ASR_OFF_ORD_RES      8'h18
`define ASR_OFF_PRE_OFS1     8'h1C
`define ASR_OFF_PRE_OFS2     8'h20
`define ASR_OFF_PRE_OFS3     8'h24
`define ASR_OFF_PRE_OFS4     8'h28

// ****************************************************************
// field layout and masks
// ****************************************************************
`define ASR_SLOT_W           5
`define ASR_ORD_SEQ_MASK     32'h3FFFFFFF
`define ASR_PRE_SEQ_MASK     32'h003FFFFF
`define ASR_PRE_LEN_LSB      20
`define ASR_PRE_LEN_MSB      21
`define ASR_RES_MASK         32'h0000FFFF
`define ASR_OFS_MASK         32'h00000FFF
`define ASR_PRE_SLOTS        4
`define ASR_LAST_SLOT        2'h3

// ****************************************************************
// reset values
// ****************************************************************
`define ASR_RST_SEQ          32'h00000000
`define ASR_RST_RES          16'h0000
`define ASR_RST_OFS          12'h000

`endif

// ---- verilog/asr_seq_result_regs.v ----
// Summary of operation
// - six 5-bit ordinary slot fields at bits 4:0 up to 29:25, rw, reset zero.
// - preempted length code at bits 21:20 means one to four conversions.
// - four 5-bit preempted slot fields, bits 4:0 to 19:15, rw, reset zero.
// - short preempted scans start at slot four minus length code, end slot four.
// - four preempted result registers, 16-bit value in bits 15:0, reset zero.
// - preempted result equals raw conversion minus that position's offset.
// - ordinary result register bits 15:0 hold latest ordinary result, read-only.
// - primary instance upper half holds second converter result in master/slave mode.
// - secondary instances keep the upper half of ordinary result at zero.
// - reserved bits read as reset value; software writes them as default.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`include "asr_defs.vh"

module asr_seq_result_regs #(
   parameter PRIMARY = 1
) (
   input  wire        clk_sys,
   input  wire        reset,
   input  wire        clk_en,
   // register port
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // ordinary conversion side
   output wire [29:0] ordinary_slot_channels,
   input  wire        ordinary_done,
   input  wire [15:0] ordinary_raw,
   input  wire        master_slave_mode,
   input  wire        second_done,
   input  wire [15:0] second_raw,
   // preempted scan side
   input  wire        preempted_start,
   output reg         preempted_req,
   output reg  [4:0]  preempted_channel,
   input  wire        preempted_done,
   input  wire [11:0] preempted_raw,
   output reg         preempted_busy,
   output reg         preempted_end
);

   // ****************************************************************
   // helpers
   // ****************************************************************

   // channel field of one preempted slot (0-based index)
   // one case arm per slot keeps the mux shallow, no shifter needed
   function [4:0] slot_channel;
      input [31:0] seq;
      input [1:0]  idx;
      begin
         case (idx)
            2'h0:    slot_channel = seq[4:0];
            2'h1:    slot_channel = seq[9:5];
            2'h2:    slot_channel = seq[14:10];
            default: slot_channel = seq[19:15];
         endcase
      end
   endfunction

   // first 0-based slot: (4 - code) in 1-based terms, so 3 - code here
   // code 2'b10, for example, starts at index 1, the second slot
   function [1:0] first_slot;
      input [1:0] code;
      begin
         first_slot = `ASR_LAST_SLOT - code;
      end
   endfunction

   // word-aligned address inside an inclusive range of register words
   function in_group;
      input [7:0] addr;
      input [7:0] lo;
      input [7:0] hi;
      begin
         in_group = (addr >= lo) && (addr <= hi) && (addr[1:0] == 2'h0);
      end
   endfunction

   // 0-based word index of an address inside a register group
   function [1:0] group_index;
      input [7:0] addr;
      input [7:0] lo;
      reg   [7:0] delta;
      begin
         delta       = addr - lo;
         group_index = delta[3:2];
      end
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   // all state below moves only while clk_en is high; reset is taken
   // regardless of clk_en, so a frozen unit can still be cleared
   // scan states; the spare code falls back to idle
   localparam ST_IDLE = 2'h0;
   localparam ST_REQ  = 2'h1;
   localparam ST_WAIT = 2'h2;

   // software-visible registers
   reg  [31:0] ordinary_sequence_3;
   reg  [31:0] preempted_sequence;
   reg  [15:0] preempted_result_value [0:3];
   reg  [11:0] preempted_offset       [0:3];
   reg  [15:0] ordinary_result_value;
   reg  [15:0] second_converter_ordinary_value;
   // scan bookkeeping
   reg  [1:0]  state;
   reg  [1:0]  next_state;
   reg  [1:0]  slot;
   reg  [1:0]  next_slot;
   reg  [15:0] diff;
   integer     i;

   // field views and decode results
   wire [1:0]  preempted_length_code;
   wire        wr_res_hit;
   wire [1:0]  wr_res_idx;
   wire        wr_ofs_hit;
   wire [1:0]  wr_ofs_idx;
   wire        upper_live;

   // live views of register fields
   assign preempted_length_code  = preempted_sequence[`ASR_PRE_LEN_MSB:`ASR_PRE_LEN_LSB];
   assign ordinary_slot_channels = ordinary_sequence_3[29:0];
   assign upper_live             = (PRIMARY != 0) && master_slave_mode;

   // ****************************************************************
   // address decode
   // ****************************************************************

   // register map, one 32-bit word each, byte offsets:
   //   0x00 ordinary sequence (slots 1 to 6)
   //   0x04 preempted sequence (slots 1 to 4, length code)
   //   0x08 to 0x14 preempted results 1 to 4
   //   0x18 ordinary result (own low half, second unit high half)
   //   0x1C to 0x28 preempted offsets 1 to 4
   // anything else, or a misaligned address, is ignored on write
   // and reads back as zero
   assign wr_res_hit = in_group(reg_addr, `ASR_OFF_PRE_RES1, `ASR_OFF_PRE_RES4);
   assign wr_res_idx = group_index(reg_addr, `ASR_OFF_PRE_RES1);
   assign wr_ofs_hit = in_group(reg_addr, `ASR_OFF_PRE_OFS1, `ASR_OFF_PRE_OFS4);
   assign wr_ofs_idx = group_index(reg_addr, `ASR_OFF_PRE_OFS1);

   // offset-corrected preempted value, wraps modulo 2^16 like a plain subtractor
   // a raw value below its offset reads back as a large number; software
   // wanting a signed view takes bit 15 as the sign
   always @* begin
      diff = {4'h0, preempted_raw} - {4'h0, preempted_offset[slot]};
   end

   // ****************************************************************
   // preempted scan sequencer
   // ****************************************************************

   // next-state logic of the scan
   // a start is only looked at while idle, so a second start during a
   // scan is dropped rather than queued; a done pulse only counts in
   // the wait state, so one arriving together with the request pulse
   // is lost and the scan stalls until the next one
   always @* begin
      next_state = state;
      next_slot  = slot;
      case (state)
         ST_IDLE: begin
            if (preempted_start) begin
               // shorter scans skip the leading slots
               next_slot  = first_slot(preempted_length_code);
               next_state = ST_REQ;
            end
         end
         ST_REQ: begin
            next_state = ST_WAIT;
         end
         ST_WAIT: begin
            if (preempted_done) begin
               // every scan ends on the fourth slot, whatever its length
               if (slot == `ASR_LAST_SLOT) begin
                  next_state = ST_IDLE;
               end else begin
                  next_slot  = slot + 2'h1;
                  next_state = ST_REQ;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // scan registers and handshake outputs
   // outputs are registered from the next state, so the request, busy
   // and end pulses line up with the state they describe
   always @(posedge clk_sys) begin
      if (reset) begin
         state             <= ST_IDLE;
         slot              <= 2'h0;
         preempted_req     <= 1'b0;
         preempted_channel <= 5'h00;
         preempted_busy    <= 1'b0;
         preempted_end     <= 1'b0;
      end else if (clk_en) begin
         state          <= next_state;
         slot           <= next_slot;
         preempted_req  <= (next_state == ST_REQ);
         preempted_busy <= (next_state != ST_IDLE);
         preempted_end  <= (state == ST_WAIT) && (next_state == ST_IDLE);
         // channel is sampled from the live slot field at request time
         if (next_state == ST_REQ) begin
            preempted_channel <= slot_channel(preempted_sequence, next_slot);
         end
      end
   end

   // ****************************************************************
   // registers written by software and hardware
   // ****************************************************************

   // writes mask reserved bits so they always read back as zero;
   // a conversion landing in the write cycle wins over the software value
   // the ordinary result has no write path at all: software cannot
   // fake a conversion there, only the converter side updates it
   always @(posedge clk_sys) begin
      if (reset) begin
         ordinary_sequence_3             <= `ASR_RST_SEQ;
         preempted_sequence              <= `ASR_RST_SEQ;
         ordinary_result_value           <= `ASR_RST_RES;
         second_converter_ordinary_value <= `ASR_RST_RES;
         for (i = 0; i < `ASR_PRE_SLOTS; i = i + 1) begin
            preempted_result_value[i] <= `ASR_RST_RES;
            preempted_offset[i]       <= `ASR_RST_OFS;
         end
      end else if (clk_en) begin
         if (reg_wr) begin
            case (reg_addr)
               `ASR_OFF_ORD_SEQ3: ordinary_sequence_3 <= reg_wdata & `ASR_ORD_SEQ_MASK;
               `ASR_OFF_PRE_SEQ:  preempted_sequence  <= reg_wdata & `ASR_PRE_SEQ_MASK;
               default: begin
               end
            endcase
            if (wr_res_hit) begin
               preempted_result_value[wr_res_idx] <= reg_wdata[15:0];
            end
            // offsets keep only their 12 low bits
            if (wr_ofs_hit) begin
               preempted_offset[wr_ofs_idx] <= reg_wdata[11:0];
            end
         end
         // hardware update placed last so it wins a same-cycle write
         if ((state == ST_WAIT) && preempted_done) begin
            preempted_result_value[slot] <= diff;
         end
         if (ordinary_done) begin
            ordinary_result_value <= ordinary_raw;
         end
         // the high half follows the second unit only while it means something
         if (second_done && upper_live) begin
            second_converter_ordinary_value <= second_raw;
         end
      end
   end

   // ****************************************************************
   // read port
   // ****************************************************************

   // data appear the cycle after the strobe; unmapped addresses read zero
   // clearing the word outside read cycles lets several units share one
   // read-data bus through a plain OR without a separate select
   always @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata <= 32'h00000000;
      end else if (clk_en) begin
         // zero unless overridden by a read below
         reg_rdata <= 32'h00000000;
         if (reg_rd) begin
            case (reg_addr)
               `ASR_OFF_ORD_SEQ3: reg_rdata <= ordinary_sequence_3;
               `ASR_OFF_PRE_SEQ:  reg_rdata <= preempted_sequence;
               `ASR_OFF_PRE_RES1: reg_rdata <= {16'h0000, preempted_result_value[0]};
               `ASR_OFF_PRE_RES2: reg_rdata <= {16'h0000, preempted_result_value[1]};
               `ASR_OFF_PRE_RES3: reg_rdata <= {16'h0000, preempted_result_value[2]};
               `ASR_OFF_PRE_RES4: reg_rdata <= {16'h0000, preempted_result_value[3]};
               `ASR_OFF_ORD_RES: begin
                  // upper half is dead outside master/slave or in secondary units
                  reg_rdata <= {(upper_live ? second_converter_ordinary_value : 16'h0000),
                                ordinary_result_value};
               end
               `ASR_OFF_PRE_OFS1: reg_rdata <= {20'h00000, preempted_offset[0]};
               `ASR_OFF_PRE_OFS2: reg_rdata <= {20'h00000, preempted_offset[1]};
               `ASR_OFF_PRE_OFS3: reg_rdata <= {20'h00000, preempted_offset[2]};
               `ASR_OFF_PRE_OFS4: reg_rdata <= {20'h00000, preempted_offset[3]};
               default:           reg_rdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // asr_seq_result_regs

// ---- verif/asr_seq_result_regs_assertions.sv ----
// *****
// register and scan checks
// *****
module asr_seq_result_regs_assertions #(
   parameter PRIMARY = 1
) (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        clk_en,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [29:0] ordinary_slot_channels,
   input wire logic        master_slave_mode,
   input wire logic        preempted_start,
   input wire logic        preempted_done,
   input wire logic        preempted_req,
   input wire logic        preempted_busy,
   input wire logic        preempted_end
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // a result taken while waiting, with more slots to go
   sequence s_mid_done;
      preempted_done && preempted_busy ##1 preempted_busy;
   endsequence
   // the last result of a scan
   sequence s_last_done;
      preempted_done && preempted_busy ##1 !preempted_busy;
   endsequence
   a_seq_resd: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata[31:30] == 2'h0)
      else $error("ordinary sequence reserved bits set");
   a_pre_resd: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata[31:22] == 10'h0)
      else $error("preempted sequence reserved bits set");
   a_res_upper: assert property (reg_rd && reg_addr inside {8'h08, 8'h0C, 8'h10, 8'h14}
      |=> reg_rdata[31:16] == 16'h0) else $error("preempted result upper half set");
   a_ord_upper: assert property (reg_rd && reg_addr == 8'h18 && (!master_slave_mode || PRIMARY == 0)
      |=> reg_rdata[31:16] == 16'h0) else $error("second result shown outside master/slave");
   a_slot_map: assert property (reg_wr && reg_addr == 8'h00 |=> ordinary_slot_channels == $past(reg_wdata[29:0]))
      else $error("slot channels do not follow register");
   a_start_req: assert property (preempted_start && !preempted_busy |=> preempted_req && preempted_busy)
      else $error("scan start gave no request");
   a_req_pulse: assert property (preempted_req |=> !preempted_req)
      else $error("request longer than one cycle");
   a_mid_req: assert property (s_mid_done |-> preempted_req)
      else $error("no request after a mid scan result");
   a_last_end: assert property (s_last_done |-> preempted_end)
      else $error("scan ended without end pulse");
   a_end_pulse: assert property (preempted_end |-> !preempted_busy ##1 !preempted_end)
      else $error("end pulse too long or busy at end");
   a_freeze_hold: assert property (!clk_en |=> $stable(reg_rdata) && $stable(preempted_busy)
      && $stable(ordinary_slot_channels)) else $error("state moved while clock enable low");
endmodule // asr_seq_result_regs_assertions

// ---- verif/adc_sequence_result_regs_test.sv ----
`include "asr_defs.vh"
module adc_sequence_result_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, rd_pending = 0, clk_en = 1;
   logic        ordinary_done = 0, second_done = 0, master_slave_mode = 0;
   logic        preempted_start = 0, preempted_done = 0, preempted_req, preempted_busy, preempted_end;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, s = 32'h8BCCE217, q [$];
   logic [15:0] ordinary_raw = 16'h0, second_raw = 16'h0, v, res [4];
   logic [11:0] preempted_raw = 12'h0, ofs [4];
   logic [29:0] ordinary_slot_channels;
   logic [4:0]  preempted_channel;
   int          n_errors = 0, samples_checked = 0, cyc = 0;

   asr_seq_result_regs #(.PRIMARY(1)) i_asr_seq_result_regs (
      .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ordinary_slot_channels(ordinary_slot_channels),
      .ordinary_done(ordinary_done), .ordinary_raw(ordinary_raw), .master_slave_mode(master_slave_mode),
      .second_done(second_done), .second_raw(second_raw), .preempted_start(preempted_start),
      .preempted_req(preempted_req), .preempted_channel(preempted_channel), .preempted_done(preempted_done),
      .preempted_raw(preempted_raw), .preempted_busy(preempted_busy), .preempted_end(preempted_end));

   // *****
   // helpers
   // *****
   initial forever #20 clk_sys = ~clk_sys;
   function automatic logic [31:0] rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // channels kept to 0..17, software never writes more
   function automatic logic [31:0] slots(int n);
      slots = 32'h0;
      for (int i = 0; i < n; i++) slots[5*i +: 5] = 5'(rnd() % 18);
   endfunction
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         n_errors++;
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 0;
   endtask
   // the note goes in first, the monitor takes it a cycle later
   task automatic rd(logic [7:0] a, logic [31:0] e);
      @(posedge clk_sys);
      reg_rd <= 1;
      reg_addr <= a;
      q.push_back(e);
      @(posedge clk_sys);
      reg_rd <= 0;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // read data stands one cycle only, so compare mid cycle
   always @(posedge clk_sys) begin
      rd_pending <= reg_rd;
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   always @(negedge clk_sys) if (rd_pending) chk("reg_rdata", reg_rdata, q.pop_front());

   // *****
   // scenarios
   // *****
   initial begin
      logic [31:0] d;
      int k, t;
      repeat (2) @(posedge clk_sys);
      reset <= 0;
      for (k = 0; k < 8; k++) rd(8'(4 * k), 32'h0);
      rd(8'h40, 32'h0);
      for (k = 0; k < 4; k++) res[k] = 16'h0;
      $display("reset values done");
      d = slots(6) | 32'hC0000000;
      wr(`ASR_OFF_ORD_SEQ3, d);
      rd(`ASR_OFF_ORD_SEQ3, d & 32'h3FFFFFFF);
      chk("slots", 32'(ordinary_slot_channels), d & 32'h3FFFFFFF);
      wr(`ASR_OFF_ORD_RES, rnd());
      rd(`ASR_OFF_ORD_RES, 32'h0);
      for (int c = 0; c < 4; c++) begin
         for (k = 0; k < 4; k++) begin
            ofs[k] = 12'(rnd());
            wr(`ASR_OFF_PRE_OFS1 + 8'(4 * k), {20'h0, ofs[k]});
         end
         d = slots(4) | (32'(c) << 20);
         wr(`ASR_OFF_PRE_SEQ, d);
         rd(`ASR_OFF_PRE_SEQ, d);
         @(posedge clk_sys);
         preempted_start <= 1;
         @(posedge clk_sys);
         preempted_start <= 0;
         for (k = 3 - c; k < 4; k++) begin
            t = 0;
            do @(negedge clk_sys); while (preempted_req !== 1'b1 && ++t < 20);
            chk("req", 32'(preempted_req), 32'h1);
            chk("channel", 32'(preempted_channel), 32'(d[5*k +: 5]));
            repeat (rnd() % 3) @(posedge clk_sys);
            @(posedge clk_sys);
            preempted_done <= 1;
            preempted_start <= 1;
            preempted_raw <= 12'(rnd());
            @(posedge clk_sys);
            preempted_done <= 0;
            preempted_start <= 0;
            res[k] = {4'h0, preempted_raw} - {4'h0, ofs[k]};
         end
         repeat (3) @(negedge clk_sys);
         chk("busy", 32'(preempted_busy), 32'h0);
         for (k = 0; k < 4; k++) rd(`ASR_OFF_PRE_RES1 + 8'(4 * k), {16'h0, res[k]});
         $display("scan with length code %0d done", c);
      end
      master_slave_mode <= 1;
      v = 16'(rnd());
      ordinary_raw <= v;
      second_raw <= ~v;
      ordinary_done <= 1;
      second_done <= 1;
      @(posedge clk_sys);
      ordinary_done <= 0;
      second_done <= 0;
      rd(`ASR_OFF_ORD_RES, {~v, v});
      master_slave_mode <= 0;
      rd(`ASR_OFF_ORD_RES, {16'h0, v});
      // a conversion finishing while the unit is frozen must not land
      clk_en <= 0;
      ordinary_raw <= ~v;
      ordinary_done <= 1;
      repeat (2) @(posedge clk_sys);
      clk_en <= 1;
      ordinary_done <= 0;
      rd(`ASR_OFF_ORD_RES, {16'h0, v});
      $display("ordinary results done");
      repeat (3) @(posedge clk_sys);
      tally_and_finish();
   end
endmodule // adc_sequence_result_regs_test

bind asr_seq_result_regs asr_seq_result_regs_assertions #(.PRIMARY(PRIMARY)) i_asr_seq_result_regs_assertions (
   .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ordinary_slot_channels(ordinary_slot_channels),
   .master_slave_mode(master_slave_mode), .preempted_start(preempted_start), .preempted_done(preempted_done),
   .preempted_req(preempted_req), .preempted_busy(preempted_busy), .preempted_end(preempted_end));
